// ### tb/irfp_src_model.sv
`timescale 1ns/1ps
module irfp_src_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Command from the bench
    input  wire logic [9:0] want,
    input  wire logic       slow,
    // Request lines towards the controller
    output logic      [9:0] lines
);
    logic [9:0] stage;
    logic [9:0] next_stage;
    logic [9:0] next_lines;

    // Slow sources raise and drop one cycle late
    always_comb
    begin
        next_stage = want;
        next_lines = slow ? stage : want;
    end

    // Sources stay quiet while reset is held
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage <= 10'h000;
            lines <= 10'h000;
        end
        else
        begin
            stage <= next_stage;
            lines <= next_lines;
        end
    end
endmodule : irfp_src_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import irfp_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        standby, rtc, port, slow, fwd, wake, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, w, prdata_ns, rd_ns;
    logic [9:0]  want, lines;
    logic [3:0]  enc, mask, lvl;
    logic [11:0] code;
    int          failures, checks, seed;

    irfp_src_model src_u (.pclk(pclk), .presetn(presetn), .want(want), .slow(slow), .lines(lines));

    irfp_top dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sd_host_unit_req(lines[0]), .mmc_req(lines[1]), .analog_frontend_interface_req(lines[2]),
        .card_controller_req(lines[3]), .usb_host_unit_req(lines[4]), .usb_function_unit_req(lines[5]),
        .compare_match_timer_req(lines[6]), .timer_underflow_source(lines[7]),
        .dma_ch4_end_source(lines[8]), .dma_ch5_end_source(lines[9]),
        .encoded_level_lines(enc), .port_interrupt(port), .cpu_interrupt_mask(mask),
        .standby(standby), .rtc_clock_running(rtc), .cpu_irq_request(fwd), .cpu_irq_code(code),
        .cpu_irq_level(lvl), .standby_wakeup(wake), .irq(irq));

    // Variant without the SD host, on the same bus and lines
    irfp_top #(.HAS_SD_HOST(1'b0)) dut_nosd_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata_ns), .pready(), .pslverr(),
        .sd_host_unit_req(lines[0]), .mmc_req(lines[1]), .analog_frontend_interface_req(lines[2]),
        .card_controller_req(lines[3]), .usb_host_unit_req(lines[4]), .usb_function_unit_req(lines[5]),
        .compare_match_timer_req(lines[6]), .timer_underflow_source(lines[7]),
        .dma_ch4_end_source(lines[8]), .dma_ch5_end_source(lines[9]),
        .encoded_level_lines(enc), .port_interrupt(port), .cpu_interrupt_mask(mask),
        .standby(standby), .rtc_clock_running(rtc), .cpu_irq_request(), .cpu_irq_code(),
        .cpu_irq_level(), .standby_wakeup(), .irq());

    // Free-running bus clock
    always #4 pclk = ~pclk;

    function automatic logic [31:0] exp_f8(input logic [9:0] v);
        return {29'h0, v[2:0]};
    endfunction : exp_f8

    function automatic logic [31:0] exp_f9(input logic [9:0] v);
        return {28'h0, v[6:3]};
    endfunction : exp_f9

    // Holds the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a slave that never answers
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        rd_ns = prdata_ns;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : settle

    task automatic bad(input string m);
        failures++;
        $display("Error at %0t: %s", $time, m);
    endtask : bad

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) bad($sformatf("register read %h expected %h", got, exp));
    endtask : chk_reg

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) bad($sformatf("status line %b expected %b", got, exp));
    endtask : chk_bit

    // Level and code only count while a source is forwarded
    task automatic chk_fwd(input logic r, input logic [3:0] l, input logic [11:0] c);
        checks++;
        if (fwd !== r || (r && (lvl !== l || code !== c)))
            bad($sformatf("forward %b/%h/%h expected %b/%h/%h", fwd, lvl, code, r, l, c));
    endtask : chk_fwd

    task automatic print_verdict;
        $display("Counts: %0d checks, %0d failures", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // Watchdog well beyond the expected run length
    initial
    begin
        #(8 * 20000);
        bad("watchdog expired");
        print_verdict;
    end

    initial
    begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
        want = 10'h000; slow = 0; enc = 4'hf; port = 0; mask = 4'h0; standby = 0; rtc = 0;
        failures = 0; checks = 0; seed = 32'h9d89;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of flags, priorities and control
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, 8'h04 * i[7:0], 32'h0);
            chk_reg(rd, 32'h0);
        end
        $display("test reset done");
        // Random request patterns, prompt and slow sources
        for (int i = 0; i < 8; i++)
        begin
            @(posedge pclk);
            want <= 10'($random(seed)) & 10'h07f;
            slow <= i[0];
            settle(3);
            apb(1'b0, OFS_FLAGS8, 32'h0);
            chk_reg(rd, exp_f8(want));
            chk_reg(rd_ns, exp_f8(want) & 32'hfffffffe);
            apb(1'b0, OFS_FLAGS9, 32'h0);
            chk_reg(rd, exp_f9(want));
        end
        // Flags frozen through standby
        @(posedge pclk);
        standby <= 1'b1;
        w = {22'h0, want};
        want <= ~want & 10'h07f;
        settle(4);
        apb(1'b0, OFS_FLAGS8, 32'h0);
        chk_reg(rd, exp_f8(w[9:0]));
        apb(1'b0, OFS_FLAGS9, 32'h0);
        chk_reg(rd, exp_f9(w[9:0]));
        standby <= 1'b0;
        want <= 10'h000;
        $display("test flags done");
        // Reserved bits and an unmapped place
        apb(1'b1, OFS_PRIO_D, 32'hffffffff);
        apb(1'b0, OFS_PRIO_D, 32'h0);
        chk_reg(rd, 32'h00000f00);
        apb(1'b1, OFS_PRIO_J, 32'hffffffff);
        apb(1'b0, OFS_PRIO_J, 32'h0);
        chk_reg(rd, 32'h00000ff0);
        chk_reg(rd_ns, 32'h00000f00);
        apb(1'b1, OFS_PRIO_J, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk_bit(err, 1'b1);
        $display("test reserved done");
        // Timer underflow against the CPU mask, with the event interrupt
        apb(1'b1, OFS_PRIO_D, 32'h500);
        apb(1'b1, OFS_MASK, 32'h1);
        mask <= 4'h2;
        want <= 10'h080;
        settle(4);
        chk_fwd(1'b1, 4'h5, CODE_TIMER_UF);
        chk_bit(irq, 1'b1);
        apb(1'b0, OFS_CURRENT, 32'h0);
        chk_reg(rd, {15'h0, 1'b1, 4'h5, CODE_TIMER_UF});
        apb(1'b1, OFS_STATUS, 32'h1);
        settle(2);
        chk_bit(irq, 1'b0);
        @(posedge pclk);
        mask <= 4'h5;
        settle(3);
        chk_fwd(1'b0, 4'h0, 12'h0);
        apb(1'b1, OFS_PRIO_D, 32'h0);
        mask <= 4'h0;
        settle(3);
        chk_fwd(1'b0, 4'h0, 12'h0);
        $display("test timer done");
        // Individual sources and the DMA tie
        apb(1'b1, OFS_PRIO_F, 32'h300);
        want <= 10'h300;
        settle(4);
        chk_fwd(1'b1, 4'h3, CODE_DMA_CH4);
        @(posedge pclk);
        want <= 10'h200;
        settle(4);
        chk_fwd(1'b1, 4'h3, CODE_DMA_CH5);
        apb(1'b1, OFS_PRIO_J, 32'h400);
        want <= 10'h010;
        settle(4);
        chk_fwd(1'b1, 4'h4, CODE_USB_HOST);
        @(posedge pclk);
        want <= 10'h000;
        $display("test individual done");
        // Every encoded pattern from 0000 to 1110
        apb(1'b1, OFS_CTRL, 32'h1);
        for (int p = 0; p < 15; p++)
        begin
            @(posedge pclk);
            enc <= p[3:0];
            settle(8);
            chk_fwd(1'b1, 4'hf - p[3:0], CODE_LEVEL_BASE + 12'h020 * p[11:0]);
        end
        @(posedge pclk);
        enc <= 4'hf;
        $display("test encoded done");
        // Standby wake by the port interrupt
        apb(1'b1, OFS_CTRL, 32'h60);
        standby <= 1'b1; rtc <= 1'b1; port <= 1'b1; mask <= 4'h5;
        settle(8);
        chk_bit(wake, 1'b1);
        // Forward, wake and pattern-change events all seen by now
        apb(1'b0, OFS_STATUS, 32'h0);
        chk_reg(rd, 32'h00000007);
        @(posedge pclk);
        mask <= 4'h6;
        settle(4);
        chk_bit(wake, 1'b0);
        @(posedge pclk);
        mask <= 4'h5;
        rtc <= 1'b0;
        settle(4);
        chk_bit(wake, 1'b0);
        $display("test wake done");
        // Reset in mid-run while in standby: flags stay at zero though lines are up
        @(posedge pclk);
        want <= 10'h045;
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        settle(3);
        apb(1'b0, OFS_FLAGS8, 32'h0);
        chk_reg(rd, 32'h0);
        apb(1'b0, OFS_PRIO_F, 32'h0);
        chk_reg(rd, 32'h0);
        $display("test mid-run reset done");
        print_verdict;
    end
endmodule : tb_top

// ### verilog/irfp_pin_sync.sv
`timescale 1ns/1ps
module irfp_pin_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Pin side and clean side
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] clean
);
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] next_clean;

    // A bit changes only once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_comb
            begin
                next_clean[i] = (ff2[i] == ff3[i]) ? ff3[i] : clean[i];
            end
        end
    endgenerate

    // Stage one feeds only stage two
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ff1   <= '0;
            ff2   <= '0;
            ff3   <= '0;
            clean <= '0;
        end
        else
        begin
            ff1   <= pin;
            ff2   <= ff1;
            ff3   <= ff2;
            clean <= next_clean;
        end
    end
endmodule : irfp_pin_sync

// ### verilog/irfp_pkg.sv
package irfp_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0]  OFS_FLAGS8  = 8'h00;
    localparam logic [7:0]  OFS_FLAGS9  = 8'h04;
    localparam logic [7:0]  OFS_PRIO_D  = 8'h08;
    localparam logic [7:0]  OFS_PRIO_F  = 8'h0c;
    localparam logic [7:0]  OFS_PRIO_J  = 8'h10;
    localparam logic [7:0]  OFS_CTRL    = 8'h14;
    localparam logic [7:0]  OFS_STATUS  = 8'h18;
    localparam logic [7:0]  OFS_MASK    = 8'h1c;
    localparam logic [7:0]  OFS_CURRENT = 8'h20;

    // Reset values
    localparam logic [7:0]  RST_FLAGS   = 8'h00;
    localparam logic [15:0] RST_PRIO    = 16'h0000;
    localparam logic [7:0]  RST_CTRL    = 8'h00;
    localparam logic [2:0]  RST_EVENTS  = 3'h0;

    // Field positions
    localparam int          POS_PRIO_HI = 8;    // Bits 11:8 of priority registers
    localparam int          POS_PRIO_MD = 4;    // Bits 7:4 of priority_reg_j
    localparam int          POS_MODE    = 0;    // ctrl: 1 = encoded-level mode
    localparam int          POS_PORT_PR = 4;    // ctrl: port interrupt priority 7:4
    localparam int          EVT_FWD     = 0;
    localparam int          EVT_WAKE    = 1;
    localparam int          EVT_LEVEL   = 2;

    // Writable masks; everything else reads zero
    localparam logic [15:0] WMASK_PRIO_D = 16'h0f00;
    localparam logic [15:0] WMASK_PRIO_F = 16'h0f00;
    localparam logic [15:0] WMASK_PRIO_J = 16'h0ff0;
    localparam logic [7:0]  WMASK_CTRL   = 8'hf1;

    // Exception codes
    localparam logic [11:0] CODE_LEVEL_BASE = 12'h200;
    localparam logic [11:0] CODE_LEVEL_LAST = 12'h3c0;
    localparam logic [11:0] CODE_USB_HOST   = 12'ha60;
    localparam logic [11:0] CODE_DMA_CH4    = 12'hb80;
    localparam logic [11:0] CODE_DMA_CH5    = 12'hba0;
    localparam logic [11:0] CODE_TIMER_UF   = 12'h6c0;
    localparam logic [3:0]  LEVEL_NONE      = 4'hf;
    localparam logic [3:0]  LEVEL_TOP       = 4'hf;

    // Arbitration slots, lowest index wins a tie
    localparam int          NSRC     = 5;
    localparam int          SRC_USB_HOST_UNIT = 0;
    localparam int          SRC_DMA4 = 1;
    localparam int          SRC_DMA5 = 2;
    localparam int          SRC_TMR  = 3;
    localparam int          SRC_LVL  = 4;

endpackage : irfp_pkg

// ### verilog/irfp_prio_arb.sv
`timescale 1ns/1ps
module irfp_prio_arb
    import irfp_pkg::*;
(
    // Candidates
    input  wire logic [NSRC-1:0]    req,
    input  wire logic [NSRC*4-1:0]  prio,
    input  wire logic [NSRC*12-1:0] code,
    input  wire logic [3:0]         cpu_interrupt_mask,
    // Winner
    output logic                    win_valid,
    output logic      [3:0]         win_level,
    output logic      [11:0]        win_code
);
    // Strict compare keeps the lower slot on a tie
    always_comb
    begin
        win_valid = 1'b0;
        win_level = 4'h0;
        win_code  = 12'h000;
        for (int i = 0; i < NSRC; i++)
        begin
            if (req[i] && prio[i*4 +: 4] > cpu_interrupt_mask && (!win_valid || prio[i*4 +: 4] > win_level))
            begin
                win_valid = 1'b1;
                win_level = prio[i*4 +: 4];
                win_code  = code[i*12 +: 12];
            end
        end
    end
endmodule : irfp_prio_arb

// ### verilog/irfp_top.sv
// Overview of operation
// - An 8-bit register shows pending requests of the SD host, multimedia card and analog front-end.
// - Both request registers clear to zero on reset and hold their contents through standby.
// - Bit 0 of the SD/card/front-end register is 1 exactly when the SD host requests.
// - Without the SD host the SD bits read zero and software writes them as zero.
// - A second 8-bit register shows card controller, USB host, USB function and compare timer requests.
// - With the RTC clock running, a port interrupt wakes from standby only above the CPU mask.
// - Encoded pattern p maps to code 0x200 plus 0x20 times p at priority 15 minus p, up to 1110.
// - Individual mode uses 0xA60 for USB host, 0xB80 and 0xBA0 for DMA 4 and 5, channel 4 winning ties.
// - Timer underflow uses code 0x6C0 in both modes with priority from bits 11:8 of register D.
// - Reserved priority bits read zero and software writes them as zero.
`timescale 1ns/1ps
module irfp_top
    import irfp_pkg::*;
#(
    parameter bit HAS_SD_HOST = 1'b1
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Peripheral request lines, same clock
    input  wire logic        sd_host_unit_req,
    input  wire logic        mmc_req,
    input  wire logic        analog_frontend_interface_req,
    input  wire logic        card_controller_req,
    input  wire logic        usb_host_unit_req,
    input  wire logic        usb_function_unit_req,
    input  wire logic        compare_match_timer_req,
    input  wire logic        timer_underflow_source,
    input  wire logic        dma_ch4_end_source,
    input  wire logic        dma_ch5_end_source,
    // External pins
    input  wire logic [3:0]  encoded_level_lines,
    input  wire logic        port_interrupt,
    // CPU and power state
    input  wire logic [3:0]  cpu_interrupt_mask,
    input  wire logic        standby,
    input  wire logic        rtc_clock_running,
    // Results
    output logic             cpu_irq_request,
    output logic      [11:0] cpu_irq_code,
    output logic      [3:0]  cpu_irq_level,
    output logic             standby_wakeup,
    output logic             irq
);
    logic [7:0]  sd_card_frontend_request_flags;
    logic [7:0]  card_usb_timer_request_flags;
    logic [15:0] priority_reg_d;
    logic [15:0] priority_reg_f;
    logic [15:0] priority_reg_j;
    logic [7:0]  ctrl;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic [3:0]  level_pins;
    logic [3:0]  level_pins_inv;
    logic        port_pin;
    logic [3:0]  level_prev;
    logic [7:0]  next_flags8;
    logic [7:0]  next_flags9;
    logic [15:0] next_prio_d;
    logic [15:0] next_prio_f;
    logic [15:0] next_prio_j;
    logic [7:0]  next_ctrl;
    logic [2:0]  next_status;
    logic [2:0]  next_mask;
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic [2:0]  events;
    logic        wr_en;
    logic        encoded_mode;
    logic [3:0]  port_prio;
    logic [NSRC-1:0]    cand_req;
    logic [NSRC*4-1:0]  cand_prio;
    logic [NSRC*12-1:0] cand_code;
    logic        win_valid;
    logic [3:0]  win_level;
    logic [11:0] win_code;
    logic        next_wakeup;

    // Address decode shared by reads and writes
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    function automatic logic mapped(input logic [7:0] addr);
        mapped = hit(addr, OFS_FLAGS8) || hit(addr, OFS_FLAGS9) || hit(addr, OFS_PRIO_D) ||
                 hit(addr, OFS_PRIO_F) || hit(addr, OFS_PRIO_J) || hit(addr, OFS_CTRL) ||
                 hit(addr, OFS_STATUS) || hit(addr, OFS_MASK) || hit(addr, OFS_CURRENT);
    endfunction : mapped

    // Pins arrive from outside the clock domain; level lines idle high, so they
    // pass inverted and the sync's reset value reads as no request
    irfp_pin_sync #(.W(5)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     ({port_interrupt, ~encoded_level_lines}),
        .clean   ({port_pin, level_pins_inv})
    );
    assign level_pins   = ~level_pins_inv;

    assign wr_en        = psel && penable && pwrite;
    assign encoded_mode = ctrl[POS_MODE];
    assign port_prio    = ctrl[POS_PORT_PR +: 4];
    assign pready       = 1'b1;     // Zero-wait slave

    // Request flags follow the lines, frozen in standby so wake context survives
    always_comb
    begin
        next_flags8 = sd_card_frontend_request_flags;
        next_flags9 = card_usb_timer_request_flags;
        if (!standby)
        begin
            next_flags8 = {5'h00, analog_frontend_interface_req, mmc_req,
                           sd_host_unit_req && HAS_SD_HOST};
            next_flags9 = {4'h0, compare_match_timer_req, usb_function_unit_req,
                           usb_host_unit_req, card_controller_req};
        end
    end

    // Software writes, reserved bits forced to zero
    always_comb
    begin
        next_prio_d = priority_reg_d;
        next_prio_f = priority_reg_f;
        next_prio_j = priority_reg_j;
        next_ctrl   = ctrl;
        next_mask   = mask;
        if (wr_en && hit(paddr, OFS_PRIO_D))
            next_prio_d = pwdata[15:0] & WMASK_PRIO_D;
        if (wr_en && hit(paddr, OFS_PRIO_F))
            next_prio_f = pwdata[15:0] & WMASK_PRIO_F;
        if (wr_en && hit(paddr, OFS_PRIO_J))
            next_prio_j = pwdata[15:0] & WMASK_PRIO_J & (HAS_SD_HOST ? 16'hffff : 16'hff0f);
        if (wr_en && hit(paddr, OFS_CTRL))
            next_ctrl = pwdata[7:0] & WMASK_CTRL;
        if (wr_en && hit(paddr, OFS_MASK))
            next_mask = pwdata[2:0];
    end

    // Candidates for the CPU; the pins serve encoded levels only in that mode
    always_comb
    begin
        cand_req  = '0;
        cand_prio = '0;
        cand_code = '0;
        cand_req[SRC_USB_HOST_UNIT] = usb_host_unit_req && !encoded_mode;
        cand_prio[SRC_USB_HOST_UNIT*4 +: 4] = priority_reg_j[POS_PRIO_HI +: 4];
        cand_code[SRC_USB_HOST_UNIT*12 +: 12] = CODE_USB_HOST;
        cand_req[SRC_DMA4] = dma_ch4_end_source && !encoded_mode;
        cand_prio[SRC_DMA4*4 +: 4] = priority_reg_f[POS_PRIO_HI +: 4];
        cand_code[SRC_DMA4*12 +: 12] = CODE_DMA_CH4;
        cand_req[SRC_DMA5] = dma_ch5_end_source && !encoded_mode;
        cand_prio[SRC_DMA5*4 +: 4] = priority_reg_f[POS_PRIO_HI +: 4];
        cand_code[SRC_DMA5*12 +: 12] = CODE_DMA_CH5;
        cand_req[SRC_TMR] = timer_underflow_source;
        cand_prio[SRC_TMR*4 +: 4] = priority_reg_d[POS_PRIO_HI +: 4];
        cand_code[SRC_TMR*12 +: 12] = CODE_TIMER_UF;
        cand_req[SRC_LVL] = encoded_mode && (level_pins != LEVEL_NONE);
        cand_prio[SRC_LVL*4 +: 4] = LEVEL_TOP - level_pins;
        cand_code[SRC_LVL*12 +: 12] = CODE_LEVEL_BASE + {3'h0, level_pins, 5'h00};
    end

    irfp_prio_arb u_arb (
        .req                (cand_req),
        .prio               (cand_prio),
        .code               (cand_code),
        .cpu_interrupt_mask (cpu_interrupt_mask),
        .win_valid          (win_valid),
        .win_level          (win_level),
        .win_code           (win_code)
    );

    // Wake needs the RTC clock for pin filtering in standby
    always_comb
    begin
        next_wakeup = standby && rtc_clock_running && port_pin && (port_prio > cpu_interrupt_mask);
    end

    // Sticky events; a set in the clearing cycle wins
    always_comb
    begin
        events = '0;
        events[EVT_FWD]   = win_valid && !cpu_irq_request;
        events[EVT_WAKE]  = next_wakeup && !standby_wakeup;
        events[EVT_LEVEL] = encoded_mode && (level_pins != level_prev);
        next_status = status;
        if (wr_en && hit(paddr, OFS_STATUS))
            next_status = status & ~pwdata[2:0];
        next_status = next_status | events;
    end

    // Read data captured in the setup phase, valid through the access phase
    always_comb
    begin
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        if (psel && !penable)
        begin
            next_prdata  = 32'h0000_0000;
            next_pslverr = !mapped(paddr);
            case (paddr)
                OFS_FLAGS8:  next_prdata[7:0]  = sd_card_frontend_request_flags;
                OFS_FLAGS9:  next_prdata[7:0]  = card_usb_timer_request_flags;
                OFS_PRIO_D:  next_prdata[15:0] = priority_reg_d;
                OFS_PRIO_F:  next_prdata[15:0] = priority_reg_f;
                OFS_PRIO_J:  next_prdata[15:0] = priority_reg_j;
                OFS_CTRL:    next_prdata[7:0]  = ctrl;
                OFS_STATUS:  next_prdata[2:0]  = status;
                OFS_MASK:    next_prdata[2:0]  = mask;
                OFS_CURRENT: next_prdata[16:0] = {cpu_irq_request, cpu_irq_level, cpu_irq_code};
                default:     next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sd_card_frontend_request_flags <= RST_FLAGS;
            card_usb_timer_request_flags   <= RST_FLAGS;
            priority_reg_d  <= RST_PRIO;
            priority_reg_f  <= RST_PRIO;
            priority_reg_j  <= RST_PRIO;
            ctrl            <= RST_CTRL;
            status          <= RST_EVENTS;
            mask            <= RST_EVENTS;
            level_prev      <= LEVEL_NONE;
            prdata          <= 32'h0000_0000;
            pslverr         <= 1'b0;
            cpu_irq_request <= 1'b0;
            cpu_irq_code    <= 12'h000;
            cpu_irq_level   <= 4'h0;
            standby_wakeup  <= 1'b0;
            irq             <= 1'b0;
        end
        else
        begin
            sd_card_frontend_request_flags <= next_flags8;
            card_usb_timer_request_flags   <= next_flags9;
            priority_reg_d  <= next_prio_d;
            priority_reg_f  <= next_prio_f;
            priority_reg_j  <= next_prio_j;
            ctrl            <= next_ctrl;
            status          <= next_status;
            mask            <= next_mask;
            level_prev      <= level_pins;
            prdata          <= next_prdata;
            pslverr         <= next_pslverr;
            cpu_irq_request <= win_valid;
            cpu_irq_code    <= win_code;
            cpu_irq_level   <= win_level;
            standby_wakeup  <= next_wakeup;
            irq             <= |(next_status & next_mask);
        end
    end

    property p_sd_bit;
        @(posedge pclk) disable iff (!presetn)
        !standby |=> sd_card_frontend_request_flags[0] == $past(sd_host_unit_req && HAS_SD_HOST);
    endproperty
    a_sd_bit: assert property (p_sd_bit) else $error("sd request bit wrong");

    property p_flags8;
        @(posedge pclk) disable iff (!presetn)
        !standby |=> sd_card_frontend_request_flags[2:1] == $past({analog_frontend_interface_req, mmc_req});
    endproperty
    a_flags8: assert property (p_flags8) else $error("card/front-end bits wrong");

    property p_hold_standby;
        @(posedge pclk) disable iff (!presetn)
        standby |=> $stable(sd_card_frontend_request_flags) && $stable(card_usb_timer_request_flags);
    endproperty
    a_hold_standby: assert property (p_hold_standby) else $error("flags changed in standby");

    property p_flags9;
        @(posedge pclk) disable iff (!presetn)
        !standby |=> card_usb_timer_request_flags == {4'h0, $past(compare_match_timer_req),
            $past(usb_function_unit_req), $past(usb_host_unit_req), $past(card_controller_req)};
    endproperty
    a_flags9: assert property (p_flags9) else $error("card/usb/timer bits wrong");

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        $rose(standby_wakeup) |-> $past(standby && rtc_clock_running && port_pin)
            && $past(port_prio) > $past(cpu_interrupt_mask);
    endproperty
    a_wake: assert property (p_wake) else $error("wake without cause");

    property p_level_code;
        @(posedge pclk) disable iff (!presetn)
        cpu_irq_request && cpu_irq_code >= CODE_LEVEL_BASE && cpu_irq_code <= CODE_LEVEL_LAST
            |-> cpu_irq_level == LEVEL_TOP - cpu_irq_code[8:5];
    endproperty
    a_level_code: assert property (p_level_code) else $error("encoded level code/priority mismatch");

    property p_dma_tie;
        @(posedge pclk) disable iff (!presetn)
        cpu_irq_request && cpu_irq_code == CODE_DMA_CH5 |-> !$past(dma_ch4_end_source);
    endproperty
    a_dma_tie: assert property (p_dma_tie) else $error("channel 5 beat channel 4");

    property p_timer_prio;
        @(posedge pclk) disable iff (!presetn)
        cpu_irq_request && cpu_irq_code == CODE_TIMER_UF |-> cpu_irq_level == $past(priority_reg_d[11:8]);
    endproperty
    a_timer_prio: assert property (p_timer_prio) else $error("timer priority mismatch");

    property p_reserved;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && paddr == OFS_PRIO_D |=> prdata[31:12] == 20'h00000 && prdata[7:0] == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

    property p_above_mask;
        @(posedge pclk) disable iff (!presetn)
        cpu_irq_request |-> cpu_irq_level > $past(cpu_interrupt_mask) && cpu_irq_level != 4'h0;
    endproperty
    a_above_mask: assert property (p_above_mask) else $error("forwarded at or below mask");

endmodule : irfp_top
